/* shared/adc_ctrl_pkg.sv */
// Purpose: Constants and carrier types for the converter sequencer control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indices are kept as printed; byte address is four times the index
package adc_ctrl_pkg;
  // ==========================================================================
  // Register map (indices; byte address = index * 4)
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
  localparam logic [7:0] IDX_CONTROL = 8'h1F;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h9E;
  localparam logic [7:0] IDX_ANALOG_SEL = 8'h9F;
  localparam logic [7:0] IDX_STATUS = 8'hA0;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'hA1;
  localparam int ADDR_LSB = 2;

  // ==========================================================================
  // Control register fields
  localparam int CTL_JUSTIFY_BIT = 7;
  localparam int CTL_REFSEL_BIT = 6;
  localparam int CTL_CHAN_LO = 2;
  localparam int CTL_GO_BIT = 1;
  localparam int CTL_ON_BIT = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hCF;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ==========================================================================
  // Analog select / clock register fields
  localparam int ASEL_CLK_LO = 4;
  localparam logic [7:0] ASEL_WRITE_MASK = 8'h7F;
  localparam logic [7:0] ASEL_RESET = 8'h0F;

  // Status and interrupt-control register fields
  localparam int STS_DONE_BIT = 0;
  localparam int STS_BUSY_BIT = 1;
  localparam int STS_POWERED_BIT = 2;
  localparam int STS_WAKE_BIT = 3;
  localparam int IRQ_DONE_EN_BIT = 0;
  localparam int IRQ_PERIPH_EN_BIT = 1;
  localparam int IRQ_GLOBAL_EN_BIT = 2;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int RC_MAX_KHZ = 500;
  localparam int RC_DIV = (CLK_MHZ * 1000 + 2 * RC_MAX_KHZ - 1) / (2 * RC_MAX_KHZ);
  localparam int CONV_PERIODS = 11;
  localparam int GAP_PERIODS = 2;
  localparam int INSTR_CYCLES = 4;
  localparam logic [2:0] CLK_RC_LOW = 3'h3;

  // Sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_CONVERT, ST_GAP} seq_state_t;

  // Result carrier
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

  // Pin control carrier
  typedef struct packed {
    logic [3:0] analog;
    logic [3:0] digital_in_en;
    logic [3:0] pullup_en;
    logic [3:0] ioc_en;
  } pin_ctrl_t;
endpackage

/* hw/adc_tad_divider.sv */
// Purpose: Conversion bit-period enable generator
// Assumes: Single clock; divider codes follow the clock-select field
// Notes: Emits one-cycle pulses at the selected divided rate
`timescale 1ns/1ps
module adc_tad_divider
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Control
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  // Enable out
  output logic tick_out
);
  // ==========================================================================
  // Period select
  logic [7:0] half_r;
  logic [7:0] cnt_r;
  logic [7:0] half_nxt;

  // Period in system clocks; x11 uses the RC-equivalent rate
  always_comb
  begin
    unique case (sel_in)
      3'h0: half_nxt = 8'h02;
      3'h4: half_nxt = 8'h04;
      3'h1: half_nxt = 8'h08;
      3'h5: half_nxt = 8'h10;
      3'h2: half_nxt = 8'h20;
      3'h6: half_nxt = 8'h40;
      default: half_nxt = 8'(adc_ctrl_pkg::RC_DIV * 2);
    endcase
  end

  // Counter restarts whenever the sequencer is idle
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !run_in)
    begin
      cnt_r <= 8'h00;
      half_r <= half_nxt;
    end
    else if (cnt_r == half_r - 8'h01)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_r + 8'h01;
  end

  assign tick_out = run_in && (cnt_r == half_r - 8'h01);
endmodule

/* hw/adc_sequencer_control.sv */
// Purpose: Register file and conversion sequencer for a 10-bit converter
// Assumes: APB slave, 125 MHz clock, sampler core outside this block
// Notes: The analog core returns its code on SAMPLE_CODE_IN when asked
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Functional notes
// (R1) Justify bit set gives right-justified result, clear gives left-justified.
// (R2) Reference bit set picks the external reference pin, else the supply.
// (R3) Control bits five and four always read zero.
// (R4) Channel field routes analog inputs zero to three to the sampler.
// (R5) Writing go starts a conversion; it reads one until finished.
// (R6) Converter-on enables the converter; off means fully powered down.
// (R7) Clock field maps codes to divide by 2..64; x11 picks RC.
// (R8) The RC conversion clock never exceeds 500 kHz.
// (R9) Each analog-select bit makes its pin analog when set.
// (R10) Analog pins lose digital input, pull-up and change interrupt.
// (R11) Software sets the direction of used analog pins to input.
// (R12) Software waits acquisition time before setting go.
// (R13) Software clears done, enables done, peripheral and global interrupts.
// (R14) Software polls go low or waits for the interrupt.
// (R15) At least two bit periods between a conversion and next acquisition.
// (R16) On completion go clears and the result pair loads.
// (R17) Conversion in Sleep is only possible with the RC clock.
// (R18) With RC clock the start is delayed one instruction cycle.
// (R19) Enabled done interrupt in Sleep wakes the core, vector or continue.
// (R20) Done in Sleep with interrupt off powers down, on bit stays.
// (R21) Sleep with non-RC clock aborts and powers down, on bit stays.
// (R22) A conversion lasts eleven bit periods.
// (R23) Completion sets the done flag and requests an enabled interrupt.
// (R24) Clearing go mid-conversion keeps the old result, then gap, reacquire.
// (R25) Right format: low holds eight LSBs; left: high holds eight MSBs.
// (R26) Unused result bits read zero.
// (R27) Reset aborts conversion and resets controls, results are kept.
module adc_sequencer_control
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Core power state
  input wire logic SLEEP_IN,
  output logic WAKE_OUT,
  output logic VECTOR_OUT,
  output logic IRQ_REQ_OUT,
  // Analog core
  input wire logic [9:0] SAMPLE_CODE_IN,
  output logic [1:0] CHANNEL_OUT,
  output logic REF_EXT_OUT,
  output logic CONV_POWER_OUT,
  output logic SAMPLE_HOLD_OUT,
  output logic CODE_STROBE_OUT,
  // Pin control
  output adc_ctrl_pkg::pin_ctrl_t PIN_CTRL_OUT
);
  // ==========================================================================
  // Registers
  logic [7:0] control_r;
  logic [7:0] analog_sel_r;
  logic [7:0] irq_ctrl_r;
  adc_ctrl_pkg::result_pair_t result_r;
  logic done_flag_r;
  logic powered_down_r;
  logic wake_r;
  logic sleep_s1_r;
  logic sleep_s2_r;
  logic [9:0] code_r;
  adc_ctrl_pkg::seq_state_t state_r;
  logic [3:0] tad_cnt_r;
  logic [2:0] delay_cnt_r;
  logic [31:0] prdata_r;

  // ==========================================================================
  // Decode
  logic [7:0] idx;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] wdata;
  logic go_write_set;
  logic go_write_clear;
  logic clk_is_rc;
  logic tick;
  logic run_tad;
  logic finish;
  logic abort_sw;
  logic abort_sleep;
  logic [7:0] control_rd;

  assign idx = PADDR_IN[adc_ctrl_pkg::ADDR_LSB +: 8];
  assign wdata = PWDATA_IN[7:0];
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_en = PSEL_IN && !PENABLE_IN && !PWRITE_IN; // Setup phase loads read data
  assign mapped = (idx == adc_ctrl_pkg::IDX_RESULT_HIGH) ||
                  (idx == adc_ctrl_pkg::IDX_CONTROL) ||
                  (idx == adc_ctrl_pkg::IDX_RESULT_LOW) ||
                  (idx == adc_ctrl_pkg::IDX_ANALOG_SEL) ||
                  (idx == adc_ctrl_pkg::IDX_STATUS) ||
                  (idx == adc_ctrl_pkg::IDX_IRQ_CTRL);
  assign go_write_set = wr_en && (idx == adc_ctrl_pkg::IDX_CONTROL) &&
                        wdata[adc_ctrl_pkg::CTL_GO_BIT];
  assign go_write_clear = wr_en && (idx == adc_ctrl_pkg::IDX_CONTROL) &&
                          !wdata[adc_ctrl_pkg::CTL_GO_BIT];
  // Low two bits of 11 mark RC; top bit is a don't-care
  assign clk_is_rc = (analog_sel_r[adc_ctrl_pkg::ASEL_CLK_LO +: 2] ==
                      adc_ctrl_pkg::CLK_RC_LOW[1:0]); // [R7] [R17]

  // Zero-wait slave; unmapped addresses flag an error
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

  // ==========================================================================
  // Sleep synchroniser, the core's sleep line is treated as external
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end
    else
    begin
      sleep_s1_r <= SLEEP_IN;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // ==========================================================================
  // Bit-period timebase
  assign run_tad = (state_r == adc_ctrl_pkg::ST_CONVERT) ||
                   (state_r == adc_ctrl_pkg::ST_GAP);

  adc_tad_divider u_div
  (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .run_in(run_tad),
    .sel_in(analog_sel_r[adc_ctrl_pkg::ASEL_CLK_LO +: 3]),
    .tick_out(tick)
  ); // [R7] [R8]

  // Sleep kills a non-RC conversion; software clear is an abort too
  assign abort_sleep = sleep_s2_r && !clk_is_rc &&
                       (state_r == adc_ctrl_pkg::ST_CONVERT ||
                        state_r == adc_ctrl_pkg::ST_DELAY); // [R21]
  assign abort_sw = go_write_clear && (state_r == adc_ctrl_pkg::ST_CONVERT ||
                                       state_r == adc_ctrl_pkg::ST_DELAY); // [R24]
  assign finish = (state_r == adc_ctrl_pkg::ST_CONVERT) && tick &&
                  (tad_cnt_r == 4'(adc_ctrl_pkg::CONV_PERIODS - 1)) &&
                  !abort_sw && !abort_sleep; // [R22]

  // ==========================================================================
  // Sequencer
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      state_r <= adc_ctrl_pkg::ST_IDLE; // [R27]
      tad_cnt_r <= 4'h0;
      delay_cnt_r <= 3'h0;
    end
    else
    begin
      unique case (state_r)
        adc_ctrl_pkg::ST_IDLE:
        begin
          tad_cnt_r <= 4'h0;
          delay_cnt_r <= 3'h0;
          if (go_write_set && control_r[adc_ctrl_pkg::CTL_ON_BIT] && !powered_down_r)
            state_r <= clk_is_rc ? adc_ctrl_pkg::ST_DELAY : adc_ctrl_pkg::ST_CONVERT; // [R5] [R18]
        end
        adc_ctrl_pkg::ST_DELAY:
        begin
          delay_cnt_r <= delay_cnt_r + 3'h1;
          if (abort_sw || abort_sleep)
            state_r <= adc_ctrl_pkg::ST_GAP;
          else if (delay_cnt_r == 3'(adc_ctrl_pkg::INSTR_CYCLES - 1))
            state_r <= adc_ctrl_pkg::ST_CONVERT; // [R18]
        end
        adc_ctrl_pkg::ST_CONVERT:
        begin
          if (abort_sw || abort_sleep)
          begin
            state_r <= adc_ctrl_pkg::ST_GAP; // [R24]
            tad_cnt_r <= 4'h0;
          end
          else if (finish)
          begin
            state_r <= adc_ctrl_pkg::ST_GAP; // [R15]
            tad_cnt_r <= 4'h0;
          end
          else if (tick)
            tad_cnt_r <= tad_cnt_r + 4'h1;
        end
        adc_ctrl_pkg::ST_GAP:
        begin
          if (tick)
          begin
            tad_cnt_r <= tad_cnt_r + 4'h1;
            if (tad_cnt_r == 4'(adc_ctrl_pkg::GAP_PERIODS - 1))
              state_r <= adc_ctrl_pkg::ST_IDLE; // [R15] [R24]
          end
        end
      endcase
    end
  end

  // Capture code from the core on every clock while converting
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      code_r <= 10'h000;
    else if (state_r == adc_ctrl_pkg::ST_CONVERT)
      code_r <= SAMPLE_CODE_IN;
  end

  // ==========================================================================
  // Control register; go is held by hardware while busy
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      control_r <= adc_ctrl_pkg::CTL_RESET; // [R27]
    else
    begin
      if (wr_en && idx == adc_ctrl_pkg::IDX_CONTROL)
        control_r <= wdata & adc_ctrl_pkg::CTL_WRITE_MASK; // [R3]
      if (go_write_set && !(control_r[adc_ctrl_pkg::CTL_ON_BIT] && !powered_down_r &&
          state_r == adc_ctrl_pkg::ST_IDLE))
        control_r[adc_ctrl_pkg::CTL_GO_BIT] <= 1'b0; // Not ready: start refused
      if (finish || abort_sleep)
        control_r[adc_ctrl_pkg::CTL_GO_BIT] <= 1'b0; // [R16] [R21]
    end
  end

  // Analog select and clock register
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      analog_sel_r <= adc_ctrl_pkg::ASEL_RESET; // [R27]
    else if (wr_en && idx == adc_ctrl_pkg::IDX_ANALOG_SEL)
      analog_sel_r <= wdata & adc_ctrl_pkg::ASEL_WRITE_MASK;
  end

  // Interrupt enables mirrored for wake and vector decisions
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      irq_ctrl_r <= 8'h00;
    else if (wr_en && idx == adc_ctrl_pkg::IDX_IRQ_CTRL)
      irq_ctrl_r <= {5'h00, wdata[2:0]};
  end

  // ==========================================================================
  // Result pair: loaded only on a full conversion, kept over reset
  always_ff @(posedge CLK_IN)
  begin
    if (finish)
    begin
      if (control_r[adc_ctrl_pkg::CTL_JUSTIFY_BIT])
        result_r <= {6'h00, code_r[9:8], code_r[7:0]}; // [R1] [R25] [R26]
      else
        result_r <= {code_r[9:2], code_r[1:0], 6'h00}; // [R1] [R25] [R26]
    end
  end

  // Done flag: set wins over a software clear
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      done_flag_r <= 1'b0;
    else if (finish)
      done_flag_r <= 1'b1; // [R23]
    else if (wr_en && idx == adc_ctrl_pkg::IDX_STATUS && wdata[adc_ctrl_pkg::STS_DONE_BIT])
      done_flag_r <= 1'b0;
  end

  // Sleep power-down while the on bit stays set
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      powered_down_r <= 1'b0;
    else if (abort_sleep)
      powered_down_r <= 1'b1; // [R21]
    else if (finish && sleep_s2_r && !irq_ctrl_r[adc_ctrl_pkg::IRQ_DONE_EN_BIT])
      powered_down_r <= 1'b1; // [R20]
    else if (!sleep_s2_r || !control_r[adc_ctrl_pkg::CTL_ON_BIT])
      powered_down_r <= 1'b0;
  end

  // Wake pulse on an enabled completion during Sleep
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      wake_r <= 1'b0;
    else
      wake_r <= finish && sleep_s2_r && irq_ctrl_r[adc_ctrl_pkg::IRQ_DONE_EN_BIT]; // [R19]
  end

  // ==========================================================================
  // Read path
  always_comb
  begin
    control_rd = control_r & adc_ctrl_pkg::CTL_WRITE_MASK; // [R3]
    control_rd[adc_ctrl_pkg::CTL_GO_BIT] = control_r[adc_ctrl_pkg::CTL_GO_BIT] ||
                                         (state_r == adc_ctrl_pkg::ST_CONVERT) ||
                                         (state_r == adc_ctrl_pkg::ST_DELAY); // [R5]
  end

  // Read flop loads in setup; one cycle stale against a same-cycle finish
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      prdata_r <= 32'h0000_0000;
    else if (rd_en)
    begin
      unique case (idx)
        adc_ctrl_pkg::IDX_RESULT_HIGH: prdata_r <= {24'h000000, result_r.high};
        adc_ctrl_pkg::IDX_CONTROL: prdata_r <= {24'h000000, control_rd};
        adc_ctrl_pkg::IDX_RESULT_LOW: prdata_r <= {24'h000000, result_r.low};
        adc_ctrl_pkg::IDX_ANALOG_SEL: prdata_r <= {24'h000000, analog_sel_r};
        adc_ctrl_pkg::IDX_STATUS: prdata_r <= {28'h0000000, wake_r, powered_down_r,
                                             run_tad, done_flag_r};
        adc_ctrl_pkg::IDX_IRQ_CTRL: prdata_r <= {24'h000000, irq_ctrl_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Loaded in setup, so the word stands through the zero-wait access cycle
  assign PRDATA_OUT = prdata_r;

  // ==========================================================================
  // Outputs to core and analog front end
  assign IRQ_REQ_OUT = done_flag_r && irq_ctrl_r[adc_ctrl_pkg::IRQ_DONE_EN_BIT] &&
                       irq_ctrl_r[adc_ctrl_pkg::IRQ_PERIPH_EN_BIT]; // [R23] [R13]
  assign WAKE_OUT = wake_r; // [R19]
  assign VECTOR_OUT = wake_r && irq_ctrl_r[adc_ctrl_pkg::IRQ_GLOBAL_EN_BIT]; // [R19]
  assign CHANNEL_OUT = control_r[adc_ctrl_pkg::CTL_CHAN_LO +: 2]; // [R4]
  assign REF_EXT_OUT = control_r[adc_ctrl_pkg::CTL_REFSEL_BIT]; // [R2]
  assign CONV_POWER_OUT = control_r[adc_ctrl_pkg::CTL_ON_BIT] && !powered_down_r; // [R6] [R20]
  // Sampler tracks whenever powered and not converting
  assign SAMPLE_HOLD_OUT = (state_r == adc_ctrl_pkg::ST_CONVERT); // [R12]
  assign CODE_STROBE_OUT = finish; // [R16]
  assign PIN_CTRL_OUT.analog = analog_sel_r[3:0]; // [R9]
  assign PIN_CTRL_OUT.digital_in_en = ~analog_sel_r[3:0]; // [R10] [R11]
  assign PIN_CTRL_OUT.pullup_en = ~analog_sel_r[3:0]; // [R10]
  assign PIN_CTRL_OUT.ioc_en = ~analog_sel_r[3:0]; // [R10]
endmodule

/* test/adc_sequencer_control_assertions.sv */
// Purpose: Port assertions for the converter sequencer control block
// Assumes: Register shadows follow APB writes at the access edge
// Notes: Bound onto the block at the foot of this file
`timescale 1ns/1ps
module adc_sequencer_control_assertions
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  // Register bus
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  // Core and analog side
  input wire logic SLEEP_IN,
  input wire logic WAKE_OUT,
  input wire logic VECTOR_OUT,
  input wire logic [1:0] CHANNEL_OUT,
  input wire logic REF_EXT_OUT,
  input wire logic CONV_POWER_OUT,
  input wire logic SAMPLE_HOLD_OUT,
  input wire logic CODE_STROBE_OUT,
  input wire adc_ctrl_pkg::pin_ctrl_t PIN_CTRL_OUT
);
  // ==========================================================================
  // Register shadows
  logic [7:0] ctl_r;
  logic [7:0] asel_r;
  logic [7:0] irq_r;
  logic wr_hit;
  assign wr_hit = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;

  // Loaded where the slave takes the write, so no lag against the design
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      ctl_r <= adc_ctrl_pkg::CTL_RESET;
      asel_r <= adc_ctrl_pkg::ASEL_RESET;
      irq_r <= 8'h00;
    end
    else if (wr_hit)
    begin
      if (PADDR_IN == 32'h0000_007C)
        ctl_r <= PWDATA_IN[7:0];
      if (PADDR_IN == 32'h0000_027C)
        asel_r <= PWDATA_IN[7:0];
      if (PADDR_IN == 32'h0000_0284)
        irq_r <= PWDATA_IN[7:0];
    end
  end

  // ==========================================================================
  // Properties
  default clocking dc @(posedge CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  // Sleep entered on a divided clock, then the core shut down
  sequence sleep_slow_s;
    $rose(SLEEP_IN) && SAMPLE_HOLD_OUT && (asel_r[5:4] != 2'h3);
  endsequence
  sequence core_off_s;
    !SAMPLE_HOLD_OUT && !CONV_POWER_OUT;
  endsequence

  zero_wait_a: assert property ((PSEL_IN && PENABLE_IN) |-> PREADY_OUT)
    else $error("Access phase without ready");
  chan_route_a: assert property (CHANNEL_OUT == ctl_r[3:2])
    else $error("Channel does not follow control");
  ref_select_a: assert property (REF_EXT_OUT == ctl_r[6])
    else $error("Reference does not follow control");
  pin_mode_a: assert property (PIN_CTRL_OUT == {asel_r[3:0], {3{~asel_r[3:0]}}})
    else $error("Pin mode does not follow analog select");
  off_power_a: assert property (!ctl_r[0] |-> !CONV_POWER_OUT)
    else $error("Converter powered while off");
  // Shortest conversion is eleven periods of two clocks
  strobe_len_a: assert property (CODE_STROBE_OUT |-> $past(SAMPLE_HOLD_OUT, 21) ##1 !CODE_STROBE_OUT)
    else $error("Conversion too short or strobe not a pulse");
  wake_pulse_a: assert property (WAKE_OUT |-> irq_r[0] ##1 !WAKE_OUT)
    else $error("Wake without enable or not a pulse");
  vector_gate_a: assert property ((WAKE_OUT || VECTOR_OUT) |-> (VECTOR_OUT == (WAKE_OUT && irq_r[2])))
    else $error("Vector not gated by global enable");
  sleep_abort_a: assert property (sleep_slow_s |-> ##[1:8] core_off_s)
    else $error("Conversion not aborted on sleep");
endmodule

bind adc_sequencer_control adc_sequencer_control_assertions chk
(
  .CLK_IN(CLK_IN),
  .SRST_IN(SRST_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT),
  .SLEEP_IN(SLEEP_IN),
  .WAKE_OUT(WAKE_OUT),
  .VECTOR_OUT(VECTOR_OUT),
  .CHANNEL_OUT(CHANNEL_OUT),
  .REF_EXT_OUT(REF_EXT_OUT),
  .CONV_POWER_OUT(CONV_POWER_OUT),
  .SAMPLE_HOLD_OUT(SAMPLE_HOLD_OUT),
  .CODE_STROBE_OUT(CODE_STROBE_OUT),
  .PIN_CTRL_OUT(PIN_CTRL_OUT)
);

/* test/adc_sequencer_control_bench.sv */
// Purpose: Self-checking bench for the converter sequencer control block
// Assumes: Zero-wait APB, read data valid at the access edge
// Notes: Reads and wakes leave notes in queues that a monitor compares
`timescale 1ns/1ps
module adc_sequencer_control_bench;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic [9:0] code = 10'h000;
  logic [31:0] prdata;
  logic pready, pslverr, wake, vect, irq, ref_ext, pwr_on, hold, strobe, err;
  logic [1:0] chan;
  adc_ctrl_pkg::pin_ctrl_t pins;
  logic [63:0] rq[$];
  logic [31:0] wq[$];
  logic [63:0] e;
  logic [31:0] rdat;
  logic [15:0] rnd = 16'h0009;
  int cyc = 0;
  int n_errors = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  adc_sequencer_control DUT
  (
    .CLK_IN(clk),
    .SRST_IN(srst),
    .PSEL_IN(psel),
    .PENABLE_IN(pen),
    .PWRITE_IN(pwr),
    .PADDR_IN(paddr),
    .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata),
    .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr),
    .SLEEP_IN(sleep),
    .WAKE_OUT(wake),
    .VECTOR_OUT(vect),
    .IRQ_REQ_OUT(irq),
    .SAMPLE_CODE_IN(code),
    .CHANNEL_OUT(chan),
    .REF_EXT_OUT(ref_ext),
    .CONV_POWER_OUT(pwr_on),
    .SAMPLE_HOLD_OUT(hold),
    .CODE_STROBE_OUT(strobe),
    .PIN_CTRL_OUT(pins)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic flag(input logic f);
    check({31'h0, f}, 32'h1);
  endtask

  // One transfer; a read notes its expected byte under a mask
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
    input logic [7:0] m);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w)
      rq.push_back({24'h0, m, 24'h0, d});
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (!pready)
      @(posedge clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Polls the go bit; bounded so a stuck conversion fails the closing go-bit check
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 32'h0000_007C, 8'h00, 8'h00);
      n++;
    end
    while (rdat[1] && n < 1500);
    check({31'h0, rdat[1]}, 32'h0);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Monitor: read data is taken at the access edge, where it stands
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (psel && pen && !pwr && pready)
    begin
      e = rq.pop_front();
      check(prdata & e[63:32], e[31:0]);
    end
    if (wake)
      check({31'h0, vect}, wq.pop_front());
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    logic [9:0] cv;
    logic [7:0] eh, el, cb;
    int t0, dv;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 32'h0000_007C, 8'h00, 8'hFF);
    apb(1'b0, 32'h0000_027C, 8'h0F, 8'hFF);
    apb(1'b1, 32'h0000_007C, 8'hFC, 8'h00);
    apb(1'b0, 32'h0000_007C, 8'hCC, 8'hFF);
    apb(1'b0, 32'h0000_0200, 8'h00, 8'hFF);
    flag(err);
    // Every divided clock code, channel and justification
    for (int c = 0; c < 7; c++)
    begin
      if (c == 3)
        continue;
      dv = 2 << (2 * (c % 4) + c / 4);
      rnd = lfsr(rnd);
      cv = rnd[9:0];
      code <= cv;
      cb = {c[0], 3'h0, 2'((c + c / 4) % 4), 2'h1};
      apb(1'b1, 32'h0000_027C, {1'b0, 3'(c), 4'h5}, 8'h00);
      apb(1'b1, 32'h0000_007C, cb, 8'h00);
      apb(1'b1, 32'h0000_007C, cb | 8'h02, 8'h00);
      t0 = cyc;
      apb(1'b0, 32'h0000_007C, cb | 8'h02, 8'hFF);
      wait_idle();
      flag(cyc - t0 >= 11 * dv + 1 && cyc - t0 <= 11 * dv + 8);
      eh = c[0] ? {6'h0, cv[9:8]} : cv[9:2];
      el = c[0] ? cv[7:0] : {cv[1:0], 6'h0};
      apb(1'b0, 32'h0000_0078, eh, 8'hFF);
      apb(1'b0, 32'h0000_0278, el, 8'hFF);
      repeat (4 * dv) @(posedge clk);
    end
    // Abort keeps the old result
    code <= ~cv;
    apb(1'b1, 32'h0000_007C, 8'h03, 8'h00);
    repeat (20) @(posedge clk);
    apb(1'b1, 32'h0000_007C, 8'h01, 8'h00);
    apb(1'b0, 32'h0000_007C, 8'h01, 8'hFF);
    apb(1'b0, 32'h0000_0078, eh, 8'hFF);
    apb(1'b0, 32'h0000_0278, el, 8'hFF);
    repeat (512) @(posedge clk);
    // Sleep on the RC clock with wake and vector enabled
    apb(1'b1, 32'h0000_0284, 8'h07, 8'h00);
    apb(1'b1, 32'h0000_027C, 8'h35, 8'h00);
    rnd = lfsr(rnd);
    cv = rnd[9:0];
    code <= cv;
    wq.push_back(32'h1);
    t0 = cyc;
    apb(1'b1, 32'h0000_007C, 8'h83, 8'h00);
    sleep <= 1'b1;
    while (!wake && cyc - t0 < 4000)
      @(posedge clk);
    flag(wake);
    flag(cyc - t0 >= 2750);
    flag(irq);
    sleep <= 1'b0;
    apb(1'b0, 32'h0000_0078, {6'h0, cv[9:8]}, 8'hFF);
    apb(1'b0, 32'h0000_0278, cv[7:0], 8'hFF);
    apb(1'b0, 32'h0000_0280, 8'h01, 8'h01);
    apb(1'b1, 32'h0000_0280, 8'h01, 8'h00);
    flag(!irq);
    apb(1'b0, 32'h0000_007C, 8'h81, 8'hFF);
    repeat (600) @(posedge clk);
    // Sleep completion with the interrupt off powers down
    cv = ~cv;
    eh = {6'h0, cv[9:8]};
    code <= cv;
    apb(1'b1, 32'h0000_0284, 8'h00, 8'h00);
    apb(1'b1, 32'h0000_007C, 8'h83, 8'h00);
    sleep <= 1'b1;
    wait_idle();
    flag(!pwr_on);
    apb(1'b0, 32'h0000_007C, 8'h81, 8'hFF);
    sleep <= 1'b0;
    repeat (600) @(posedge clk);
    // Sleep on a divided clock aborts
    apb(1'b1, 32'h0000_027C, 8'h05, 8'h00);
    apb(1'b1, 32'h0000_007C, 8'h00, 8'h00);
    apb(1'b1, 32'h0000_007C, 8'h81, 8'h00);
    apb(1'b1, 32'h0000_007C, 8'h83, 8'h00);
    sleep <= 1'b1;
    repeat (8) @(posedge clk);
    flag(!pwr_on && !hold);
    apb(1'b0, 32'h0000_007C, 8'h01, 8'h01);
    sleep <= 1'b0;
    // Reset in mid-conversion keeps the result
    apb(1'b1, 32'h0000_027C, 8'h35, 8'h00);
    apb(1'b1, 32'h0000_007C, 8'h83, 8'h00);
    repeat (8) @(posedge clk);
    flag(hold);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    flag(!hold);
    apb(1'b0, 32'h0000_007C, 8'h00, 8'hFF);
    apb(1'b0, 32'h0000_027C, 8'h0F, 8'hFF);
    apb(1'b0, 32'h0000_0078, eh, 8'hFF);
    give_verdict();
  end

  // Watchdog well beyond the expected run of about 9.4k cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule
